// file: shared/dac_update_cfg.svh
// Functional notes
// R1 - a complete frame puts its 16-bit code into the addressed input register
// R2 - strobe high holds every output register, input writes go nowhere; the code stores such writes in the input registers
// R3 - strobe low makes output registers transparent to input registers
// R4 - host writes one channel, then lowers strobe while writing the other
// R5 - output register copies only an input register written since last update
// R6 - synchronous mode updates outputs right after the 24th falling edge
// R7 - host may hold strobe low permanently or pulse it low
// R8 - mask bit 0 leaves channel to strobe; 1 updates after each write
// R9 - command 110 loads mask from bit 1 (channel b), bit 0 (channel a)
// R10 - mask resets to 0, strobe controls both channels
// R11 - mask frame takes mode only from the lowest two bits
// R12 - command 100: bits 5:4 pick mode, bits 1:0 pick channels
// R13 - host sends every frame most significant bit first
// R14 - byte-wide host keeps sync low across bytes, raises after last
// R15 - host data valid at falling serial clock edge, where it is sampled
// R16 - 24-bit frame: 2 spare, 3 command, 3 address, 16 data bits
// R17 - sync rising before 24th edge discards frame, changes nothing
// R18 - mode 00 normal, 01 1k to ground, 10 100k, 11 high impedance
// R19 - per-channel pending flag set on write, cleared on output update
`ifndef DAC_UPDATE_CFG_SVH
`define DAC_UPDATE_CFG_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define FRAME_LAST 5'h17
`define FRAME_DONE 5'h18
`define CMD_MSB 21
`define CMD_LSB 19
`define ADR_MSB 18
`define ADR_LSB 16
`define DATA_MSB 15
`define PD_MSB 5
`define PD_LSB 4

// ----------------------------------------------------------------
// command and address codes
// ----------------------------------------------------------------
`define CMD_WR_IN 3'h0
`define CMD_UPD 3'h1
`define CMD_WR_UPD_ALL 3'h2
`define CMD_WR_UPD 3'h3
`define CMD_PWR 3'h4
`define CMD_SWRST 3'h5
`define CMD_MASK 3'h6
`define ADR_CH_A 3'h0
`define ADR_CH_B 3'h1
`define ADR_ALL 3'h7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MASK_RST 2'h0
`define PD_RST 2'h0
`define STRB_SYNC_RST 3'h7
`define STRB_LVL_RST 1'h1

`endif

// file: shared/dac_update_pkg.sv
package dac_update_pkg;

    // link side: bit counter and shift chain, cleared by sync high
    typedef struct packed {
        logic [4:0] cnt;
        logic [22:0] shift;
    } link_s;

    // core side state
    typedef struct packed {
        logic [2:0] strb_sync;
        logic strb_lvl;
        logic [2:0] tog_sync;
        logic [1:0][15:0] in_reg;
        logic [1:0][15:0] dac_reg;
        logic [1:0] mask;
        logic [1:0] pend;
        logic [1:0][1:0] pd_mode;
    } ctrl_s;

endpackage

// file: design/serial_frame_rx.sv
`timescale 1ns/1ps
`include "dac_update_cfg.svh"

module serial_frame_rx
    import dac_update_pkg::*;
(
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic sync_n_i,
    input wire logic sdin_i,
    output logic [23:0] frame_word_o,
    output logic frame_tog_o
);

    link_s lr;
    link_s ln;
    logic take;

    // ------------------------------------------------------------
    // shift chain, msb first, sampled on falling edge
    // ------------------------------------------------------------
    always_comb begin
        ln = lr;
        take = (lr.cnt == `FRAME_LAST); // [R16]
        if (lr.cnt < `FRAME_LAST) begin
            ln.shift = {lr.shift[21:0], sdin_i};
            ln.cnt = lr.cnt + 5'h1;
        end else if (take) begin
            ln.cnt = `FRAME_DONE; // extra edges ignored until sync rises
        end
    end

    // sync high clears the partial frame even if sclk has stopped
    always_ff @(negedge sclk_i or posedge sync_n_i) begin
        if (sync_n_i) begin
            lr <= '0; // [R17]
        end else begin
            lr <= ln;
        end
    end

    // word stays put for a whole frame, so the core reads it safely
    // once the toggle has crossed; async reset as sclk may be idle
    always_ff @(negedge sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_word_o <= 24'h0;
            frame_tog_o <= 1'b0;
        end else if (take && !sync_n_i) begin
            frame_word_o <= {lr.shift, sdin_i}; // [R16]
            frame_tog_o <= ~frame_tog_o;
        end
    end

    AST_NO_PARTIAL: assert property ( // [R17]
        @(negedge sclk_i) disable iff (!rst_n_i || sync_n_i)
        (lr.cnt != `FRAME_LAST) |=> $stable(frame_tog_o))
        else $error("frame accepted before 24th edge");

endmodule

// file: design/dual_dac_update_control.sv
`timescale 1ns/1ps
`include "dac_update_cfg.svh"

module dual_dac_update_control
    import dac_update_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic sync_n_i,
    input wire logic sdin_i,
    input wire logic load_strobe_n_i,
    output logic [15:0] dac_a_code_o,
    output logic [15:0] dac_b_code_o,
    output logic [1:0] pwrdn_mode_hi_o,
    output logic [1:0] pwrdn_mode_lo_o,
    output logic [1:0] update_mask_o,
    output logic [1:0] pending_o
);

    ctrl_s r;
    ctrl_s n;
    logic [23:0] frame_word;
    logic frame_tog;
    logic fev;
    logic swrst;
    logic [2:0] cmd;
    logic [2:0] adr;
    logic [1:0] sel;
    logic [1:0] wr;
    logic [1:0] cmd_upd;
    logic [1:0] pend_pre;
    logic [1:0] upd;

    // ------------------------------------------------------------
    // serial link, runs on the host's clock
    // ------------------------------------------------------------
    serial_frame_rx u_rx (
        .rst_n_i(rst_n_i),
        .sclk_i(sclk_i),
        .sync_n_i(sync_n_i),
        .sdin_i(sdin_i),
        .frame_word_o(frame_word),
        .frame_tog_o(frame_tog)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        // strobe pin: three stages, level changes once stages 2 and 3 agree
        n.strb_sync = {r.strb_sync[1:0], load_strobe_n_i};
        if (r.strb_sync[1] == r.strb_sync[2]) begin
            n.strb_lvl = r.strb_sync[2];
        end
        // frame toggle: an edge between stages 2 and 3 marks one frame
        n.tog_sync = {r.tog_sync[1:0], frame_tog};
        fev = r.tog_sync[1] ^ r.tog_sync[2];
        cmd = frame_word[`CMD_MSB:`CMD_LSB];
        adr = frame_word[`ADR_MSB:`ADR_LSB];
        case (adr)
            `ADR_CH_A: begin
                sel = 2'h1;
            end
            `ADR_CH_B: begin
                sel = 2'h2;
            end
            `ADR_ALL: begin
                sel = 2'h3;
            end
            default: begin
                sel = 2'h0; // reserved address selects nothing
            end
        endcase
        wr = 2'h0;
        cmd_upd = 2'h0;
        swrst = 1'b0;
        // command decode; spare top bits never looked at
        if (fev) begin
            case (cmd)
                `CMD_WR_IN: begin
                    wr = sel; // [R1]
                end
                `CMD_UPD: begin
                    cmd_upd = sel;
                end
                `CMD_WR_UPD_ALL: begin
                    wr = sel;
                    cmd_upd = 2'h3;
                end
                `CMD_WR_UPD: begin
                    wr = sel;
                    cmd_upd = sel;
                end
                `CMD_PWR: begin
                    // address ignored, bits 1:0 pick channels
                    for (int i = 0; i < 2; i++) begin
                        if (frame_word[i]) begin
                            n.pd_mode[i] = frame_word[`PD_MSB:`PD_LSB]; // [R12] [R18]
                        end
                    end
                end
                `CMD_SWRST: begin
                    swrst = 1'b1;
                    n.in_reg = '0;
                    n.dac_reg = '0;
                    n.pend = 2'h0;
                    if (frame_word[0]) begin
                        n.mask = `MASK_RST;
                        n.pd_mode = '0;
                    end
                end
                `CMD_MASK: begin
                    n.mask = frame_word[1:0]; // [R9] [R11]
                end
                default: begin
                end
            endcase
        end
        // per channel: write, pending flag, transfer
        for (int i = 0; i < 2; i++) begin
            pend_pre[i] = r.pend[i] | wr[i]; // [R19]
            // mask 1 acts as a strobe held low; strobe high latches
            upd[i] = pend_pre[i] & (~r.strb_lvl | r.mask[i] | cmd_upd[i]); // [R2] [R3] [R5] [R8]
            if (!swrst) begin
                if (wr[i]) begin
                    n.in_reg[i] = frame_word[`DATA_MSB:0]; // [R1]
                end
                if (upd[i]) begin
                    n.dac_reg[i] = n.in_reg[i]; // [R3] [R6]
                end
                // a write landing with its own update is consumed
                n.pend[i] = pend_pre[i] & ~upd[i]; // [R19]
            end
        end
    end

    // ------------------------------------------------------------
    // state register, synchronous reset
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            r <= '0;
            r.strb_sync <= `STRB_SYNC_RST;
            r.strb_lvl <= `STRB_LVL_RST;
            r.mask <= `MASK_RST; // [R10]
        end else begin
            r <= n;
        end
    end

    // outputs straight from the state register
    assign dac_a_code_o = r.dac_reg[0];
    assign dac_b_code_o = r.dac_reg[1];
    assign pwrdn_mode_hi_o = {r.pd_mode[1][1], r.pd_mode[0][1]};
    assign pwrdn_mode_lo_o = {r.pd_mode[1][0], r.pd_mode[0][0]};
    assign update_mask_o = r.mask;
    assign pending_o = r.pend;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_WRITE_INPUT: assert property ( // [R1]
        (fev && cmd == `CMD_WR_IN && adr == `ADR_CH_B)
        |=> r.in_reg[1] == $past(frame_word[15:0]))
        else $error("input register b not written");

    AST_HOLD_HIGH: assert property ( // [R2]
        (r.strb_lvl && !r.mask[0] && !fev)
        |=> $stable(r.dac_reg[0]))
        else $error("output a changed while strobe high");

    AST_TRANSPARENT: assert property ( // [R3]
        (!r.strb_lvl && r.pend[0])
        |=> (r.dac_reg[0] == r.in_reg[0]) && !r.pend[0])
        else $error("output a not transparent with strobe low");

    AST_ONLY_WRITTEN: assert property ( // [R5]
        (!r.pend[1] && !fev) |=> $stable(r.dac_reg[1]))
        else $error("output b updated without a write");

    AST_SYNC_UPDATE: assert property ( // [R6]
        (fev && cmd == `CMD_WR_IN && adr == `ADR_ALL && r.mask == 2'h3)
        |=> r.dac_reg[0] == $past(frame_word[15:0])
            && r.dac_reg[1] == r.dac_reg[0])
        else $error("masked channels not updated after frame");

    AST_MASK_IGNORES_PIN: assert property ( // [R8]
        (r.mask[1] && r.strb_lvl && fev && cmd == `CMD_WR_IN
         && adr == `ADR_CH_B)
        |=> r.dac_reg[1] == $past(frame_word[15:0]))
        else $error("mask bit did not override strobe");

    AST_MASK_LOAD: assert property ( // [R9]
        (fev && cmd == `CMD_MASK) |=> r.mask == $past(frame_word[1:0]))
        else $error("mask not loaded from bits 1:0");

    AST_MASK_RESET: assert property ( // [R10]
        $past(!rst_n_i) |-> (r.mask == 2'h0 && r.pend == 2'h0))
        else $error("mask not zero after reset");

    AST_PWRDN_DECODE: assert property ( // [R18]
        (fev && cmd == `CMD_PWR && frame_word[1])
        |=> r.pd_mode[1] == $past(frame_word[5:4])
            && pwrdn_mode_hi_o[1] == r.pd_mode[1][1])
        else $error("power mode of channel b wrong");

    AST_PENDING_SET: assert property ( // [R19]
        (fev && cmd == `CMD_WR_IN && adr == `ADR_CH_A
         && r.strb_lvl && !r.mask[0])
        |=> r.pend[0] ##1 r.pend[0] || !r.strb_lvl || fev)
        else $error("pending flag not set by write");

endmodule

// file: testbench/serial_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// host serial port model: clock idles low, data valid at falling edge
// ----------------------------------------------------------------
module serial_host_model (
    output logic sclk_o,
    output logic sync_n_o,
    output logic sdin_o
);
    // one sync pulse at start: the frame counter has no other reset,
    // and a level set at time zero may be missed by the flop
    initial begin
        sclk_o = 1'b0;
        sync_n_o = 1'b0;
        sdin_o = 1'b0;
        #10;
        sync_n_o = 1'b1;
    end

    // n below 24 raises sync early, which aborts the frame
    task automatic send_frame(input logic [23:0] word, input int n);
        sync_n_o = 1'b0;
        #32;
        for (int i = 23; i > 23 - n; i--) begin // msb first
            sclk_o = 1'b1;
            sdin_o = word[i]; // settles half a period before sampling
            #32;
            sclk_o = 1'b0;
            #32;
            if (i % 8 == 0) begin // byte gap, sync held low
                #100;
            end
        end
        sync_n_o = 1'b1;
        sdin_o = ~sdin_o; // released line must not look held
        #128;
    endtask
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps
`include "dac_update_cfg.svh"

module tb;
    logic sys_clk_i = 1'b0;
    logic rst_n_i;
    logic load_strobe_n_i = 1'b1;
    logic sclk, sync_n, sdin;
    logic [15:0] dac_a, dac_b;
    logic [1:0] pd_hi, pd_lo, mask, pend;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;

    dual_dac_update_control u_dut (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .sclk_i(sclk),
        .sync_n_i(sync_n),
        .sdin_i(sdin),
        .load_strobe_n_i(load_strobe_n_i),
        .dac_a_code_o(dac_a),
        .dac_b_code_o(dac_b),
        .pwrdn_mode_hi_o(pd_hi),
        .pwrdn_mode_lo_o(pd_lo),
        .update_mask_o(mask),
        .pending_o(pend)
    );

    serial_host_model u_host (
        .sclk_o(sclk),
        .sync_n_o(sync_n),
        .sdin_o(sdin)
    );

    initial begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d errors=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // spare top bits set to ones: the device must ignore them
    task automatic wr(input logic [2:0] cmd, input logic [2:0] adr,
                      input logic [15:0] d);
        u_host.send_frame({2'h3, cmd, adr, d}, 24);
        repeat (8) @(posedge sys_clk_i);
    endtask

    // wait covers the three-flop filter plus the copy stage
    task automatic strobe(input logic lvl);
        load_strobe_n_i <= lvl;
        repeat (8) @(posedge sys_clk_i);
    endtask

    // hang guard: whole run needs about a thousand cycles
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            complete_run();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        // x to 0 is a falling edge: clears the link word and toggle
        rst_n_i <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        check({dac_a, dac_b}, 32'h0);
        check({24'h0, pd_hi, pd_lo, mask, pend}, 32'h0);
        wr(`CMD_WR_IN, `ADR_CH_A, 16'h1234);
        check({dac_a, 14'h0, pend}, {16'h0, 16'h1});
        strobe(1'b0);
        check({dac_a, 14'h0, pend}, {16'h1234, 16'h0});
        strobe(1'b1);
        // a written first; strobe low updates a at once, b at the end of its own frame
        wr(`CMD_WR_IN, `ADR_CH_A, 16'h1111);
        check({16'h0, dac_a}, 32'h1234);
        load_strobe_n_i <= 1'b0;
        wr(`CMD_WR_IN, `ADR_CH_B, 16'h2222);
        check({dac_a, dac_b}, 32'h1111_2222);
        check({30'h0, pend}, 32'h0);
        strobe(1'b1);
        // channel a to synchronous mode, junk in the ignored bits
        wr(`CMD_MASK, 3'h5, 16'hfffd);
        check({30'h0, mask}, 32'h1);
        wr(`CMD_WR_IN, `ADR_CH_A, 16'habcd);
        check({dac_a, 14'h0, pend}, {16'habcd, 16'h0});
        wr(`CMD_WR_IN, `ADR_CH_B, 16'h5a5a);
        check({dac_b, 14'h0, pend}, {16'h2222, 16'h2});
        // frame cut one bit short must leave everything alone
        u_host.send_frame({2'h0, `CMD_WR_IN, `ADR_ALL, 16'h0f0f}, 23);
        repeat (8) @(posedge sys_clk_i);
        check({dac_a, dac_b}, 32'habcd_2222);
        check({28'h0, mask, pend}, 32'h6);
        strobe(1'b0);
        check({dac_a, dac_b}, 32'habcd_5a5a);
        strobe(1'b1);
        // every power mode on channel b only
        for (int m = 0; m < 4; m++) begin
            wr(`CMD_PWR, 3'h2, {10'h3ff, m[1:0], 4'h2});
            check({30'h0, pd_hi}, {30'h0, m[1], 1'b0});
            check({30'h0, pd_lo}, {30'h0, m[0], 1'b0});
        end
        wr(`CMD_PWR, 3'h0, {10'h0, 2'h3, 4'h1});
        check({28'h0, pd_hi, pd_lo}, 32'hf);
        // both channels synchronous: all-address write updates both
        wr(`CMD_MASK, 3'h0, 16'h0003);
        wr(`CMD_WR_IN, `ADR_ALL, 16'h7e7e);
        check({dac_a, dac_b}, 32'h7e7e_7e7e);
        wr(`CMD_WR_IN, `ADR_CH_B, 16'h0b0b);
        check({dac_b, 14'h0, pend}, {16'h0b0b, 16'h0});
        // back to pin control; software write, update and reset commands
        wr(`CMD_MASK, 3'h0, 16'h0000);
        check({30'h0, mask}, 32'h0);
        wr(`CMD_WR_UPD, `ADR_CH_A, 16'hc001);
        check({dac_a, 14'h0, pend}, {16'hc001, 16'h0});
        wr(`CMD_WR_IN, `ADR_CH_B, 16'hc002);
        wr(`CMD_UPD, `ADR_CH_B, 16'h0000);
        check({dac_b, 14'h0, pend}, {16'hc002, 16'h0});
        wr(`CMD_WR_UPD_ALL, `ADR_CH_A, 16'hc003);
        check({dac_a, dac_b}, 32'hc003_c002);
        wr(`CMD_SWRST, 3'h0, 16'h0001);
        check({dac_a, dac_b}, 32'h0);
        check({24'h0, pd_hi, pd_lo, mask, pend}, 32'h0);
        complete_run();
    end
endmodule
